// ---- logic/rsp_pkg.sv ----
// Shared constants for the two-wire clock/RAM serial port.
// Assumes both ends are compiled after this package.
package rsp_pkg;
	// ********************
	// Address space
	// ********************
	localparam int MEM_DEPTH = 64;
	localparam int PTR_W = 6;
	localparam logic [PTR_W-1:0] PTR_RESET = 6'h00;
	localparam int CLOCK_REGS = 8;
	// Slave address byte with direction bit clear
	localparam logic [7:0] SLAVE_ADDR = 8'hD0;
	localparam logic [6:0] SLAVE_ADDR7 = 7'h68;
	// ********************
	// Timing of the master
	// ********************
	localparam int REF_MHZ = 200;
	localparam real SCL_LOW_US = 4.7;
	localparam real SCL_HIGH_US = 4.0;
	localparam real BUS_FREE_US = 4.7;
	localparam int SCL_LOW_CYC = int'($ceil(SCL_LOW_US * REF_MHZ));
	localparam int SCL_HIGH_CYC = int'($ceil(SCL_HIGH_US * REF_MHZ));
	localparam int BUS_FREE_CYC = int'($ceil(BUS_FREE_US * REF_MHZ));
	localparam int TIMER_W = 11;
	localparam logic [7:0] MEM_RESET = 8'h00;
endpackage

// ---- logic/rsp_if.sv ----
// Two-wire link between the master end and the clock/RAM slave end.
// Resolves the open-drain lines from the enables itself, not in the bench.
`timescale 1ns/1ps
`default_nettype none
interface rsp_if;
	// Master clock line: out value and enable (enable low means driving)
	logic scl_o;
	logic scl_oe_n;
	// Data line, open drain, from both ends
	logic m_sda_o;
	logic m_sda_oe_n;
	logic s_sda_o;
	logic s_sda_oe_n;
	// Resolved levels
	logic scl;
	logic sda;
	assign scl = scl_oe_n ? 1'b1 : scl_o;
	assign sda = (m_sda_oe_n ? 1'b1 : m_sda_o) & (s_sda_oe_n ? 1'b1 : s_sda_o);
	modport master (output scl_o, output scl_oe_n, output m_sda_o, output m_sda_oe_n, input scl, input sda);
	modport slave (output s_sda_o, output s_sda_oe_n, input scl, input sda);
endinterface
`default_nettype wire

// ---- logic/rsp_slave.sv ----
// Slave end: 64-byte clock/RAM space reached over the two-wire link.
// Assumes the link clock is the master's clock line, seen as a clock
// port here, and that power-fail arrives asynchronously.
`timescale 1ns/1ps
`default_nettype none
module rsp_slave (
	rsp_if.slave link,
	input wire logic scl_clk,
	input wire logic arst_n,
	input wire logic power_fail
);
	typedef enum logic [2:0] {
		RSP_IDLE = 3'b000,
		RSP_ADDR = 3'b001,
		RSP_WPTR = 3'b010,
		RSP_WDAT = 3'b011,
		RSP_READ = 3'b100,
		RSP_IGNR = 3'b101
	} rsp_state_t;

	typedef struct packed {
		rsp_state_t st;
		logic [3:0] bitc;
		logic [7:0] sh;
		logic [rsp_pkg::PTR_W-1:0] ptr;
		logic rw;
		logic ack_phase;
	} rsp_s_t;

	// ********************
	// Storage and power-fail sync
	// ********************
	logic [7:0] mem [rsp_pkg::MEM_DEPTH];
	logic [2:0] pf_sync_q;
	logic pf;
	logic start_ev;
	logic stop_ev;
	rsp_s_t s_q;
	rsp_s_t s_d;
	logic mem_we;
	logic out_low_q;
	logic out_low_d;

	// Three stages; the first is only read by the second
	always_ff @(posedge scl_clk or negedge arst_n) begin
		if (!arst_n) begin
			pf_sync_q <= 3'b000;
		end else begin
			pf_sync_q <= {pf_sync_q[1:0], power_fail};
		end
	end
	// Power fail clears only once stages two and three agree; while they differ it reads as set
	assign pf = (pf_sync_q[1] == pf_sync_q[2]) ? pf_sync_q[2] : 1'b1;

	// ********************
	// Start and stop detection
	// ********************
	// START detector
	// Data falls while the clock line is high; latched on the data edge itself
	logic start_q;
	logic stop_q;
	logic start_clr_q;
	logic stop_clr_q;
	always_ff @(negedge link.sda or negedge arst_n) begin
		if (!arst_n) begin
			start_q <= 1'b0;
		end else if (link.scl) begin
			start_q <= ~start_clr_q;
		end
	end
	always_ff @(posedge link.sda or negedge arst_n) begin
		if (!arst_n) begin
			stop_q <= 1'b0;
		end else if (link.scl) begin
			stop_q <= ~stop_clr_q;
		end
	end
	// Toggle handshake: flag is live while it differs from its clear copy
	assign start_ev = start_q ^ start_clr_q;
	assign stop_ev = stop_q ^ stop_clr_q;
	always_ff @(posedge scl_clk or negedge arst_n) begin
		if (!arst_n) begin
			start_clr_q <= 1'b0;
			stop_clr_q <= 1'b0;
		end else begin
			start_clr_q <= start_q;
			stop_clr_q <= stop_q;
		end
	end

	// ********************
	// Bit engine, sampled on rising clock line
	// ********************
	always_comb begin
		s_d = s_q;
		mem_we = 1'b0;
		// START restarts the frame even mid-byte (repeated start)
		if (start_ev) begin
			// The rise that reports START already carries the first address bit
			s_d.st = RSP_ADDR;
			s_d.sh = {s_q.sh[6:0], link.sda};
			s_d.bitc = 4'h1;
			s_d.ack_phase = 1'b0;
		end else if (stop_ev) begin
			s_d.st = RSP_IDLE;
		end
		if (!s_d.ack_phase && s_d.st != RSP_IDLE && s_d.st != RSP_IGNR && !start_ev) begin
			// Eight data bits then one acknowledge slot
			s_d.sh = {s_q.sh[6:0], link.sda};
			s_d.bitc = s_q.bitc + 4'h1;
			if (s_q.bitc == 4'h7) begin
				s_d.ack_phase = 1'b1;
			end
		end else if (s_d.ack_phase && !start_ev) begin
			s_d.ack_phase = 1'b0;
			s_d.bitc = 4'h0;
			case (s_q.st)
				RSP_ADDR: begin
					// Only the own address opens an access
					// Foreign address: drop off until next START
					if (s_q.sh[7:1] != rsp_pkg::SLAVE_ADDR7) begin
						s_d.st = RSP_IGNR;
					end else if (s_q.sh[0]) begin
						// Read begins at whatever the pointer holds
						s_d.st = RSP_READ;
					end else begin
						s_d.st = RSP_WPTR;
					end
				end
				RSP_WPTR: begin
					// First byte of a write loads the pointer
					s_d.ptr = s_q.sh[rsp_pkg::PTR_W-1:0];
					s_d.st = RSP_WDAT;
				end
				RSP_WDAT: begin
					// Store then advance; six bits wrap 63 to 0
					mem_we = 1'b1;
					s_d.ptr = s_q.ptr + 6'h01;
				end
				RSP_READ: begin
					// Advance only on master acknowledge (data low)
					if (!link.sda) begin
						s_d.ptr = s_q.ptr + 6'h01;
					end else begin
						// Not acknowledged: release and wait for STOP
						s_d.st = RSP_IGNR;
					end
				end
				default: begin
					s_d.st = RSP_IGNR;
				end
			endcase
		end
		// Power fail aborts, clears pointer, blocks inputs
		if (pf) begin
			s_d.st = RSP_IDLE;
			s_d.ptr = rsp_pkg::PTR_RESET;
			s_d.bitc = 4'h0;
			s_d.ack_phase = 1'b0;
			mem_we = 1'b0;
		end
	end

	always_ff @(posedge scl_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '{st: RSP_IDLE, bitc: 4'h0, sh: 8'h00, ptr: rsp_pkg::PTR_RESET, rw: 1'b0, ack_phase: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// Byte space written on acknowledged data bytes
	always_ff @(posedge scl_clk) begin
		if (mem_we) begin
			mem[s_q.ptr] <= s_q.sh;
		end
	end

	// ********************
	// Data line driver, updated on falling clock line
	// ********************
	// Data changes only while the clock line is low
	always_comb begin
		out_low_d = 1'b0;
		if (!pf && (s_q.st != RSP_IDLE) && (s_q.st != RSP_IGNR)) begin
			if (s_q.ack_phase && s_q.st != RSP_READ) begin
				// Acknowledge address, pointer and data bytes
				out_low_d = (s_q.st != RSP_ADDR) || (s_q.sh[7:1] == rsp_pkg::SLAVE_ADDR7);
			end else if (s_q.st == RSP_READ && !s_q.ack_phase) begin
				// Shift out the byte at the pointer, MSB first
				out_low_d = ~mem[s_q.ptr][3'(7 - s_q.bitc)];
			end
		end
	end
	// Held through the whole high phase; only falls update it
	always_ff @(negedge scl_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_low_q <= 1'b0;
		end else begin
			out_low_q <= out_low_d;
		end
	end
	assign link.s_sda_o = 1'b0;
	assign link.s_sda_oe_n = ~out_low_q;
endmodule // rsp_slave
`default_nettype wire

// ---- logic/rsp_master.sv ----
// Master end: drives the clock line from ref_clk and runs byte commands.
// Assumes the user holds cmd fields stable while cmd_valid is high.
`timescale 1ns/1ps
`default_nettype none
module rsp_master (
	rsp_if.master link,
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic cmd_start,
	input wire logic cmd_stop,
	input wire logic cmd_read,
	input wire logic cmd_last,
	input wire logic [7:0] cmd_wdata,
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	output logic rsp_nack
);
	typedef enum logic [2:0] {
		RSM_IDLE = 3'b000,
		RSM_START = 3'b001,
		RSM_BIT = 3'b010,
		RSM_STOP = 3'b011,
		RSM_FREE = 3'b100
	} rsm_state_t;

	typedef struct packed {
		rsm_state_t st;
		logic [rsp_pkg::TIMER_W-1:0] tmr;
		logic [1:0] ph;
		logic [3:0] bitc;
		logic [8:0] sh;
		logic scl;
		logic sda;
		logic stop_after;
		logic rd;
		logic rsp_v;
		logic [7:0] rdata;
		logic nack;
	} rsm_s_t;

	localparam logic [rsp_pkg::TIMER_W-1:0] T_LOW = rsp_pkg::TIMER_W'(rsp_pkg::SCL_LOW_CYC);
	localparam logic [rsp_pkg::TIMER_W-1:0] T_HIGH = rsp_pkg::TIMER_W'(rsp_pkg::SCL_HIGH_CYC);
	localparam logic [rsp_pkg::TIMER_W-1:0] T_FREE = rsp_pkg::TIMER_W'(rsp_pkg::BUS_FREE_CYC);

	rsm_s_t m_q;
	rsm_s_t m_d;
	logic [2:0] sda_sync_q;
	logic sda_in;

	// ********************
	// Data line input sync
	// ********************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sda_sync_q <= 3'b111;
		end else begin
			sda_sync_q <= {sda_sync_q[1:0], link.sda};
		end
	end
	assign sda_in = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_sync_q[2];

	// ********************
	// Sequencer: one timer shared by every phase
	// ********************
	// Clock rate limit
	// Each bit stays low for two 4.7 us waits and high for 4 us, so SCL stays under 100 kHz
	always_comb begin
		m_d = m_q;
		m_d.rsp_v = 1'b0;
		if (m_q.tmr != '0) begin
			m_d.tmr = m_q.tmr - 1'b1;
		end else begin
			case (m_q.st)
				RSM_IDLE: begin
					// Begin only with the clock line high; the data line is not checked
					// Data may still be held low by our own acknowledge between read bytes
					if (cmd_valid && m_q.scl) begin
						m_d.sh = cmd_read ? {8'hFF, cmd_last} : {cmd_wdata, 1'b1};
						m_d.rd = cmd_read;
						m_d.stop_after = cmd_stop;
						m_d.bitc = 4'h0;
						m_d.ph = 2'b00;
						m_d.st = cmd_start ? RSM_START : RSM_BIT;
					end
				end
				RSM_START: begin
					// Data falls while clock high; repeated start re-raises both first
					// Repeated start: the slave may still hold its acknowledge low
					if (m_q.scl && m_q.sda && !sda_in) begin
						// Clock low first so the slave lets go of the data line
						m_d.scl = 1'b0;
						m_d.tmr = T_LOW;
					end else if (!m_q.scl || !m_q.sda) begin
						m_d.sda = 1'b1;
						m_d.scl = m_q.sda;
						m_d.tmr = T_LOW;
					end else begin
						m_d.sda = 1'b0;
						m_d.tmr = T_HIGH;
						m_d.st = RSM_BIT;
					end
				end
				RSM_BIT: begin
					case (m_q.ph)
						2'b00: begin
							// Data set only with the clock low
							m_d.scl = 1'b0;
							m_d.ph = 2'b01;
							m_d.tmr = T_LOW;
						end
						2'b01: begin
							// Ninth bit: released on a write byte, ack on a read byte unless it is the last
							m_d.sda = m_q.sh[8];
							m_d.ph = 2'b10;
							m_d.tmr = T_LOW;
						end
						default: begin
							// Clock high half, data sampled as the clock is raised
							m_d.scl = 1'b1;
							m_d.sh = {m_q.sh[7:0], sda_in};
							m_d.tmr = T_HIGH;
							m_d.ph = 2'b00;
							m_d.bitc = m_q.bitc + 4'h1;
							// Eight bits and an acknowledge slot
							if (m_q.bitc == 4'h8) begin
								m_d.rdata = m_q.sh[7:0];
								m_d.nack = sda_in;
								m_d.rsp_v = 1'b1;
								m_d.st = m_q.stop_after ? RSM_STOP : RSM_IDLE;
							end
						end
					endcase
					// Reading: release data for the eight data bits
					if (m_q.ph == 2'b01 && m_q.rd && m_q.bitc != 4'h8) begin
						m_d.sda = 1'b1;
					end
				end
				RSM_STOP: begin
					// Clock low, data low, clock high, then data rises
					if (m_q.scl && m_q.sda == 1'b0) begin
						m_d.sda = 1'b1;
						m_d.tmr = T_FREE;
						m_d.st = RSM_FREE;
					end else if (m_q.scl) begin
						m_d.scl = 1'b0;
						m_d.tmr = T_LOW;
					end else if (m_q.sda) begin
						m_d.sda = 1'b0;
						m_d.tmr = T_LOW;
					end else begin
						m_d.scl = 1'b1;
						m_d.tmr = T_HIGH;
					end
				end
				RSM_FREE: begin
					m_d.st = RSM_IDLE;
				end
				default: begin
					m_d.st = RSM_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			m_q <= '{st: RSM_IDLE, tmr: '0, ph: 2'b00, bitc: 4'h0, sh: 9'h1FF, scl: 1'b1, sda: 1'b1,
				stop_after: 1'b0, rd: 1'b0, rsp_v: 1'b0, rdata: 8'h00, nack: 1'b0};
		end else begin
			m_q <= m_d;
		end
	end

	// Outputs; lines are released (enable high) whenever their level is high
	assign cmd_ready = (m_q.st == RSM_IDLE) && (m_q.tmr == '0) && m_q.scl;
	assign rsp_valid = m_q.rsp_v;
	assign rsp_rdata = m_q.rdata;
	assign rsp_nack = m_q.nack;
	assign link.scl_o = 1'b0;
	assign link.scl_oe_n = m_q.scl;
	assign link.m_sda_o = 1'b0;
	assign link.m_sda_oe_n = m_q.sda;
endmodule // rsp_master
`default_nettype wire

// ---- testbench/rsp_chk_sva.sv ----
// Checker for the two-wire link between master and slave ends.
// Assumes plain copies of the link signals, sampled on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module rsp_chk_sva (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic m_sda_oe_n,
	input wire logic s_sda_oe_n
);
	localparam int HOLD_MAX = rsp_pkg::SCL_HIGH_CYC + 100;
	logic scl_p_q, sda_p_q, first_q, wr_q, rd_q;
	logic [11:0] scl_cnt_q, sda_cnt_q;
	logic [3:0] bit_q;
	logic [7:0] shift_q;
	logic rise, start, ack_bit, addr_hit;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// Edge and condition decode on the sampled lines
	assign rise = scl & ~scl_p_q;
	assign start = scl & scl_p_q & sda_p_q & ~sda;
	assign ack_bit = rise & (bit_q == 4'h8);
	assign addr_hit = shift_q[7:1] == rsp_pkg::SLAVE_ADDR7;
	// Byte tracker; counters saturate so idle stretches stay long
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_p_q <= 1'h1;
			sda_p_q <= 1'h1;
			scl_cnt_q <= 12'hFFF;
			sda_cnt_q <= 12'hFFF;
			bit_q <= 4'h0;
			shift_q <= 8'h00;
			first_q <= 1'h0;
			wr_q <= 1'h0;
			rd_q <= 1'h0;
		end else begin
			scl_p_q <= scl;
			sda_p_q <= sda;
			scl_cnt_q <= (scl != scl_p_q) ? 12'h000 : scl_cnt_q + {11'h000, scl_cnt_q != 12'hFFF};
			sda_cnt_q <= (sda != sda_p_q) ? 12'h000 : sda_cnt_q + {11'h000, sda_cnt_q != 12'hFFF};
			if (start) begin
				bit_q <= 4'h0;
				first_q <= 1'h1;
			end else if (ack_bit) begin
				bit_q <= 4'h0;
				first_q <= 1'h0;
				wr_q <= first_q ? addr_hit & ~shift_q[0] : wr_q;
				rd_q <= first_q ? addr_hit & shift_q[0] : rd_q & ~sda;
			end else if (rise) begin
				bit_q <= bit_q + 4'h1;
				shift_q <= {shift_q[6:0], sda};
			end
		end
	end
	// ****
	// Assertions
	// ****
	property p_hi_time;
		(!scl && scl_p_q) |-> scl_cnt_q >= 12'(rsp_pkg::SCL_HIGH_CYC - 1);
	endproperty
	a_hi_time: assert property (p_hi_time) else $error("clock high phase too short");
	property p_lo_time;
		rise |-> scl_cnt_q >= 12'(rsp_pkg::SCL_LOW_CYC - 1);
	endproperty
	a_lo_time: assert property (p_lo_time) else $error("clock low phase too short");
	property p_bus_free;
		(start && scl_cnt_q > sda_cnt_q) |-> sda_cnt_q >= 12'(rsp_pkg::BUS_FREE_CYC - 1);
	endproperty
	a_bus_free: assert property (p_bus_free) else $error("bus free time too short");
	property p_start_clk;
		start |-> ##[1:HOLD_MAX] !scl;
	endproperty
	a_start_clk: assert property (p_start_clk) else $error("no clock after start");
	property p_stable;
		(scl && scl_p_q) |-> $stable(s_sda_oe_n);
	endproperty
	a_stable: assert property (p_stable) else $error("slave data moved in clock high");
	property p_ack_match;
		(ack_bit && first_q && addr_hit) |-> !s_sda_oe_n;
	endproperty
	a_ack_match: assert property (p_ack_match) else $error("own address not acknowledged");
	property p_nack_other;
		(ack_bit && first_q && !addr_hit) |-> s_sda_oe_n;
	endproperty
	a_nack_other: assert property (p_nack_other) else $error("foreign address acknowledged");
	property p_ack_data;
		(ack_bit && !first_q && wr_q) |-> !s_sda_oe_n;
	endproperty
	a_ack_data: assert property (p_ack_data) else $error("written byte not acknowledged");
	property p_slave_quiet;
		(rise && bit_q != 4'h8 && (first_q || wr_q)) |-> s_sda_oe_n;
	endproperty
	a_slave_quiet: assert property (p_slave_quiet) else $error("slave drove a received bit");
	property p_master_rel;
		(rise && bit_q != 4'h8 && !first_q && rd_q) |-> m_sda_oe_n;
	endproperty
	a_master_rel: assert property (p_master_rel) else $error("master drove a read bit");
endmodule // rsp_chk_sva
`default_nettype wire

// ---- testbench/test_rtc_serial_slave_port.sv ----
// Bench joining master and slave ends across the link interface.
// Assumes byte commands complete within 30000 ref_clk cycles.
`timescale 1ns/1ps
`default_nettype none
module test_rtc_serial_slave_port;
	logic ref_clk = 1'h0;
	logic arst_n = 1'h0;
	logic power_fail = 1'h0;
	logic cmd_valid = 1'h0;
	logic cmd_start = 1'h0;
	logic cmd_stop = 1'h0;
	logic cmd_read = 1'h0;
	logic cmd_last = 1'h0;
	logic [7:0] cmd_wdata = 8'h00;
	logic cmd_ready, rsp_valid, rsp_nack;
	logic [7:0] rsp_rdata;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	rsp_if link();
	always #2.5 ref_clk = ~ref_clk;
	rsp_master u_rsp_master (.link(link), .ref_clk(ref_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
		.cmd_last(cmd_last), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.rsp_nack(rsp_nack));
	rsp_slave u_rsp_slave (.link(link), .scl_clk(link.scl), .arst_n(arst_n), .power_fail(power_fail));
	rsp_chk_sva u_rsp_chk_sva (.ref_clk(ref_clk), .arst_n(arst_n), .scl(link.scl), .sda(link.sda),
		.m_sda_oe_n(link.m_sda_oe_n), .s_sda_oe_n(link.s_sda_oe_n));
	// Verdict and end of run
	task automatic close_out;
		if (error_cnt == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One byte command: flags are start, stop, read, last
	task automatic xfer(input logic [3:0] fl, input logic [7:0] wd, input logic en, input logic [7:0] ed);
		int n;
		{cmd_start, cmd_stop, cmd_read, cmd_last} = fl;
		cmd_wdata = wd;
		cmd_valid = 1'h1;
		n = 0;
		while (cmd_ready !== 1'h1 && n < 5000) begin
			@(negedge ref_clk);
			n++;
		end
		// Ready was settled, so the next rising edge takes it
		@(negedge ref_clk);
		cmd_valid = 1'h0;
		n = 0;
		while (rsp_valid !== 1'h1 && n < 30000) begin
			@(negedge ref_clk);
			n++;
		end
		check({7'h00, rsp_valid}, 8'h01);
		check({7'h00, rsp_nack}, {7'h00, en});
		if (fl[1]) begin
			check(rsp_rdata, ed);
		end
	endtask
	// Write across the top of the space so the pointer wraps
	task automatic t_write;
		xfer(4'h8, rsp_pkg::SLAVE_ADDR, 1'h0, 8'h00);
		xfer(4'h0, 8'h3F, 1'h0, 8'h00);
		xfer(4'h0, 8'h11, 1'h0, 8'h00);
		xfer(4'h4, 8'h22, 1'h0, 8'h00);
	endtask
	// Random read with repeated start, acked then nacked
	task automatic t_rand_read;
		xfer(4'h8, rsp_pkg::SLAVE_ADDR, 1'h0, 8'h00);
		xfer(4'h0, 8'h3F, 1'h0, 8'h00);
		xfer(4'h8, rsp_pkg::SLAVE_ADDR | 8'h01, 1'h0, 8'h00);
		xfer(4'h2, 8'h00, 1'h0, 8'h11);
		xfer(4'h7, 8'h00, 1'h1, 8'h22);
	endtask
	// Foreign address must be left unanswered
	task automatic t_bad_addr;
		xfer(4'hC, rsp_pkg::SLAVE_ADDR ^ 8'h02, 1'h1, 8'h00);
	endtask
	// Nacked byte left pointer in place, plain read starts there
	task automatic t_cur_read;
		xfer(4'h8, rsp_pkg::SLAVE_ADDR | 8'h01, 1'h0, 8'h00);
		xfer(4'h7, 8'h00, 1'h1, 8'h22);
	endtask
	// Hang guard sized for twelve byte commands
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 400000) begin
			error_cnt++;
			close_out();
		end
	end
	initial begin
		repeat (6) @(negedge ref_clk);
		arst_n = 1'h1;
		repeat (4) @(negedge ref_clk);
		t_write();
		t_rand_read();
		t_bad_addr();
		t_cur_read();
		close_out();
	end
endmodule // test_rtc_serial_slave_port
`default_nettype wire
